// ===== bra_pkg.sv
// Package for the bit-reversed X write address unit
// Assumes: APB slave with 32-bit data, one aligned word per register
`default_nettype none
package bra_pkg;
  // ------------------------------------------------------------------
  // Register offsets (byte addresses)
  // ------------------------------------------------------------------
  localparam logic [7:0] BRA_OFS_BIT_REVERSE_CONTROL = 8'h00;
  localparam logic [7:0] BRA_OFS_ADDRESSING_MODE     = 8'h04;
  localparam logic [7:0] BRA_OFS_STATUS              = 8'h08;
  // ------------------------------------------------------------------
  // Field positions and reset values
  // ------------------------------------------------------------------
  localparam int          BRA_ENABLE_BIT      = 15;
  localparam int          BRA_MOD_W           = 15;
  localparam int          BRA_XMOD_EN_BIT     = 15;
  localparam int          BRA_PSEL_LSB        = 8;
  localparam logic [3:0]  BRA_NO_POINTER      = 4'hf;
  localparam logic [15:0] BRA_CTRL_RESET      = 16'h0000;
  localparam logic [15:0] BRA_MODE_RESET      = 16'h0f00;
  // ------------------------------------------------------------------
  // Addressing modes from instruction decode
  // ------------------------------------------------------------------
  typedef enum logic [2:0] {
    BRA_AM_DIRECT    = 3'h0,
    BRA_AM_INDIRECT  = 3'h1,
    BRA_AM_POST_INC  = 3'h2,
    BRA_AM_POST_DEC  = 3'h3,
    BRA_AM_PRE_INC   = 3'h4,
    BRA_AM_PRE_DEC   = 3'h5,
    BRA_AM_REG_OFS   = 3'h6,
    BRA_AM_LIT_OFS   = 3'h7
  } bra_mode_t;
  // ------------------------------------------------------------------
  // Bus slave states
  // ------------------------------------------------------------------
  typedef enum logic [1:0] {
    BRA_BUS_IDLE = 2'b01,
    BRA_BUS_DONE = 2'b10
  } bra_bus_t;
endpackage
`default_nettype wire

// ===== bra_rev_add.sv
// Reverse-carry adder: carries travel from msb toward lsb
// Assumes: purely combinational, used inside the write address unit
`default_nettype none
module bra_rev_add
  import bra_pkg::*;
#(
  parameter int W = 16
)(
  input  wire logic [W-1:0] a,
  input  wire logic [W-1:0] b,
  input  wire logic [W-1:0] field_mask,
  output logic      [W-1:0] sum
);
  logic [W:0] carry;
  // ------------------------------------------------------------------
  // Per-bit reverse ripple
  // ------------------------------------------------------------------
  assign carry[W] = 1'b0;
  genvar i;
  generate
    for (i = 0; i < W; i++)
    begin : g_bit
      logic m;
      assign m = field_mask[i];
      assign sum[i] = m ? (a[i] ^ b[i] ^ carry[i+1]) : a[i];
      assign carry[i] = m & ((a[i] & b[i]) | (carry[i+1] & (a[i] ^ b[i])));
    end
  endgenerate
endmodule
`default_nettype wire

// ===== bra_apb_regs.sv
// APB register slave for the bit-reverse and mode control words
// Assumes: APB master on pclk, zero wait-state capable, 32-bit data
`default_nettype none
module bra_apb_regs
  import bra_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [15:0] status_in,
  output logic             pready,
  output logic             pslverr,
  output logic      [31:0] prdata,
  output logic      [15:0] bit_reverse_control,
  output logic      [15:0] addressing_mode_control,
  output logic             ctrl_written
);
  typedef struct packed {
    bra_bus_t    st;
    logic        rdy;
    logic        err;
    logic [31:0] rdata;
    logic [15:0] brc;
    logic [15:0] amc;
    logic        wr;
  } bra_regs_t;
  bra_regs_t s_r, s_nxt;
  // ------------------------------------------------------------------
  // Access decode; answer in the cycle after setup
  // ------------------------------------------------------------------
  always_comb
  begin
    s_nxt = s_r;
    s_nxt.rdy = 1'b0;
    s_nxt.err = 1'b0;
    s_nxt.wr = 1'b0;
    unique case (s_r.st)
      BRA_BUS_IDLE:
      begin
        if (psel && !penable)
        begin
          s_nxt.st = BRA_BUS_DONE;
          s_nxt.rdy = 1'b1;
          s_nxt.rdata = 32'h0000_0000;
          unique case (paddr)
            BRA_OFS_BIT_REVERSE_CONTROL:
              s_nxt.rdata = {16'h0000, s_r.brc};
            BRA_OFS_ADDRESSING_MODE:
              s_nxt.rdata = {16'h0000, s_r.amc};
            BRA_OFS_STATUS:
            begin
              s_nxt.rdata = {16'h0000, status_in};
              s_nxt.err = pwrite;
            end
            default:
              s_nxt.err = 1'b1;
          endcase
        end
      end
      BRA_BUS_DONE:
      begin
        // Write lands only at the edge that completes the access phase
        s_nxt.st = BRA_BUS_IDLE;
        if (psel && penable && pwrite)
        begin
          if (paddr == BRA_OFS_BIT_REVERSE_CONTROL)
          begin
            s_nxt.brc = pwdata[15:0];
            s_nxt.wr = 1'b1;
          end
          if (paddr == BRA_OFS_ADDRESSING_MODE)
            s_nxt.amc = pwdata[15:0];
        end
      end
      default:
        s_nxt.st = BRA_BUS_IDLE;
    endcase
  end
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      s_r <= '{BRA_BUS_IDLE, 1'b0, 1'b0, 32'h0000_0000,
               BRA_CTRL_RESET, BRA_MODE_RESET, 1'b0};
    end
    else
    begin
      s_r <= s_nxt;
    end
  end
  assign pready = s_r.rdy;
  assign pslverr = s_r.err;
  assign prdata = s_r.rdata;
  assign bit_reverse_control = s_r.brc;
  assign addressing_mode_control = s_r.amc;
  assign ctrl_written = s_r.wr;
endmodule
`default_nettype wire

// ===== bra_agu.sv
// X write address unit with bit-reversed effective address generation
// Assumes: decode presents one write request per cycle, pointer file
// lives in the core; new pointer value is written back by the core.
//
// Our own choices: the APB slave port and the address map.
`default_nettype none
module bra_agu
  import bra_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic             pready,
  output logic             pslverr,
  output logic      [31:0] prdata,
  input  wire logic        wr_req,
  input  wire logic [2:0]  wr_mode,
  input  wire logic [3:0]  wr_ptr_sel,
  input  wire logic        wr_byte,
  input  wire logic [15:0] wr_ptr_val,
  input  wire logic [15:0] wr_offset,
  input  wire logic        rd_req,
  input  wire logic [3:0]  rd_ptr_sel,
  input  wire logic [15:0] rd_ea_in,
  input  wire logic [15:0] modulo_start,
  input  wire logic [15:0] modulo_end,
  output logic             ea_valid,
  output logic      [15:0] ea_out,
  output logic             ptr_wb,
  output logic      [15:0] ptr_new,
  output logic             rev_active,
  output logic             rd_valid,
  output logic      [15:0] rd_ea_out
);
  logic [15:0] brc;
  logic [15:0] amc;
  logic        ctrl_wr;
  logic [15:0] status_w;
  // ------------------------------------------------------------------
  // Register slave
  // ------------------------------------------------------------------
  bra_apb_regs u_regs (
    .pclk                    (pclk),
    .presetn                 (presetn),
    .psel                    (psel),
    .penable                 (penable),
    .pwrite                  (pwrite),
    .paddr                   (paddr),
    .pwdata                  (pwdata),
    .status_in               (status_w),
    .pready                  (pready),
    .pslverr                 (pslverr),
    .prdata                  (prdata),
    .bit_reverse_control     (brc),
    .addressing_mode_control (amc),
    .ctrl_written            (ctrl_wr)
  );
  // ------------------------------------------------------------------
  // Decode of mode and enable
  // ------------------------------------------------------------------
  logic [3:0]  reverse_pointer_select;
  logic        reverse_enable;
  logic        xmod_en;
  logic [3:0]  xmod_ptr;
  logic [14:0] pivot_modifier;
  logic        inc_mode;
  logic        act;
  logic [15:0] step;
  logic [15:0] field_mask;
  logic [15:0] rev_sum;
  assign reverse_pointer_select = amc[BRA_PSEL_LSB +: 4];
  assign xmod_ptr = amc[3:0];
  assign xmod_en = amc[BRA_XMOD_EN_BIT];
  assign reverse_enable = brc[BRA_ENABLE_BIT];
  assign pivot_modifier = brc[BRA_MOD_W-1:0];
  assign inc_mode = (wr_mode == BRA_AM_PRE_INC) ||
                    (wr_mode == BRA_AM_POST_INC);
  assign act = wr_req && reverse_enable && inc_mode && !wr_byte &&
               (reverse_pointer_select != BRA_NO_POINTER) &&
               (wr_ptr_sel == reverse_pointer_select);
  assign step = {pivot_modifier, 1'b0};
  // Buffer field spans every bit up to twice the modifier's top bit
  always_comb
  begin
    field_mask = 16'h0000;
    for (int k = 0; k < 16; k++)
      if (k == 0 || step[15:0] >= (16'h0001 << k))
        field_mask[k] = 1'b1;
  end
  // Neither operand is reversed: the carry runs backwards
  bra_rev_add #(.W(16)) u_radd (
    .a          (wr_ptr_val),
    .b          (step),
    .field_mask (field_mask),
    .sum        (rev_sum)
  );
  // ------------------------------------------------------------------
  // Normal address generation with modulo correction
  // ------------------------------------------------------------------
  logic [15:0] norm_next;
  logic [15:0] norm_ea;
  logic        norm_wb;
  logic [15:0] inc;
  logic [15:0] rd_fix;
  function automatic logic [15:0] modfix(input logic [15:0] v);
    logic [15:0] r;
    r = v;
    if (v > modulo_end)
      r = 16'(v - modulo_end + modulo_start - 16'h0002);
    else if (v < modulo_start)
      r = 16'(v + modulo_end - modulo_start + 16'h0002);
    return r;
  endfunction
  always_comb
  begin
    inc = wr_byte ? 16'h0001 : 16'h0002;
    norm_next = wr_ptr_val;
    norm_ea = wr_ptr_val;
    norm_wb = 1'b0;
    unique case (wr_mode)
      BRA_AM_POST_INC:
      begin
        norm_next = 16'(wr_ptr_val + inc);
        norm_wb = 1'b1;
      end
      BRA_AM_POST_DEC:
      begin
        norm_next = 16'(wr_ptr_val - inc);
        norm_wb = 1'b1;
      end
      BRA_AM_PRE_INC:
      begin
        norm_next = 16'(wr_ptr_val + inc);
        norm_ea = norm_next;
        norm_wb = 1'b1;
      end
      BRA_AM_PRE_DEC:
      begin
        norm_next = 16'(wr_ptr_val - inc);
        norm_ea = norm_next;
        norm_wb = 1'b1;
      end
      BRA_AM_REG_OFS, BRA_AM_LIT_OFS:
        norm_ea = 16'(wr_ptr_val + wr_offset);
      default:
      begin
        norm_ea = wr_ptr_val;
      end
    endcase
    if (xmod_en && xmod_ptr != BRA_NO_POINTER && wr_ptr_sel == xmod_ptr)
    begin
      norm_next = modfix(norm_next);
      norm_ea = modfix(norm_ea);
    end
    rd_fix = rd_ea_in;
    if (xmod_en && xmod_ptr != BRA_NO_POINTER && rd_ptr_sel == xmod_ptr)
      rd_fix = modfix(rd_ea_in);
  end
  // ------------------------------------------------------------------
  // Registered outputs
  // ------------------------------------------------------------------
  typedef struct packed {
    logic        ev;
    logic [15:0] ea;
    logic        wb;
    logic [15:0] pn;
    logic        ra;
    logic        rv;
    logic [15:0] rea;
    logic        ctw;
  } bra_out_t;
  bra_out_t o_r, o_nxt;
  always_comb
  begin
    o_nxt = o_r;
    o_nxt.ev = wr_req;
    o_nxt.ra = act;
    o_nxt.rv = rd_req;
    o_nxt.rea = rd_fix;
    o_nxt.ctw = ctrl_wr;
    if (act)
    begin
      // Modulo is bypassed here; reversal has priority
      o_nxt.pn = rev_sum;
      o_nxt.wb = wr_req;
      if (wr_mode == BRA_AM_PRE_INC)
        o_nxt.ea = {rev_sum[15:1], 1'b0};
      else
        o_nxt.ea = {wr_ptr_val[15:1], 1'b0};
    end
    else
    begin
      o_nxt.pn = norm_next;
      o_nxt.wb = wr_req && norm_wb;
      o_nxt.ea = norm_ea;
    end
  end
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      o_r <= '0;
    end
    else
    begin
      o_r <= o_nxt;
    end
  end
  assign status_w = {14'h0000, o_r.ctw, o_r.ra};
  assign ea_valid = o_r.ev;
  assign ea_out = o_r.ea;
  assign ptr_wb = o_r.wb;
  assign ptr_new = o_r.pn;
  assign rev_active = o_r.ra;
  assign rd_valid = o_r.rv;
  assign rd_ea_out = o_r.rea;
endmodule
`default_nettype wire

// ===== bra_agu_properties.sv
// Concurrent checks on the ports of the bit-reversed write address unit
// Assumes: bound to bra_agu; one clock pclk, async reset presetn
`default_nettype none
module bra_agu_properties
  import bra_pkg::*;
(
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        wr_req,
  input wire logic [2:0]  wr_mode,
  input wire logic [3:0]  wr_ptr_sel,
  input wire logic        wr_byte,
  input wire logic [15:0] wr_ptr_val,
  input wire logic        rd_req,
  input wire logic        ea_valid,
  input wire logic [15:0] ea_out,
  input wire logic        ptr_wb,
  input wire logic [15:0] ptr_new,
  input wire logic        rev_active,
  input wire logic        rd_valid
);
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  apb_answer_a: assert property (psel && !penable |=> pready)
    else $error("no answer in access cycle");
  apb_once_a: assert property (pready |=> !pready)
    else $error("ready held too long");
  ea_follow_a: assert property (ea_valid == $past(wr_req))
    else $error("address answer not one cycle after request");
  rev_cause_a: assert property (rev_active |-> $past(wr_req) &&
    $past(wr_ptr_sel) != BRA_NO_POINTER &&
    ($past(wr_mode) == BRA_AM_POST_INC || $past(wr_mode) == BRA_AM_PRE_INC))
    else $error("reversal without its conditions");
  byte_normal_a: assert property ($past(wr_byte) |-> !rev_active)
    else $error("reversal on byte access");
  rev_lsb_a: assert property (rev_active |-> !ea_out[0])
    else $error("reversed address lsb set");
  rev_source_a: assert property (rev_active &&
    $past(wr_mode) == BRA_AM_POST_INC |->
    ea_out == {$past(wr_ptr_val[15:1]), 1'b0})
    else $error("post increment address not the pointer");
  rev_wb_a: assert property (rev_active |-> ptr_wb)
    else $error("reversed pointer not written back");
  norm_post_a: assert property (ea_valid && !rev_active &&
    $past(wr_mode) == BRA_AM_POST_INC |-> ea_out == $past(wr_ptr_val))
    else $error("normal post increment address wrong");
  rd_follow_a: assert property (rd_valid == $past(rd_req))
    else $error("read unit answer late");

  cover property (rev_active);
  cover property (pslverr);
  cover property (rd_valid && ea_valid == 1'b0);
endmodule
`default_nettype wire

// ===== bra_core_model.sv
// Core side model: holds the write pointer and takes its write-back
// Assumes: bench loads an aligned buffer base through load
`default_nettype none
module bra_core_model (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        load,
  input  wire logic [15:0] load_val,
  input  wire logic        ptr_wb,
  input  wire logic [15:0] ptr_new,
  output logic      [15:0] ptr
);
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      ptr <= 16'h0000;
    else if (load)
      ptr <= load_val;
    else if (ptr_wb)
      ptr <= ptr_new;
  end
endmodule
`default_nettype wire

// ===== tb_top.sv
// Self-checking bench for the bit-reversed write address unit
// Assumes: bra_agu over APB, bra_core_model holds the write pointer
`default_nettype none
module tb_top
  import bra_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic        pclk, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata;
  logic        pready, pslverr, wr_req = 0, wr_byte = 0, rd_req = 0, ld = 0;
  logic [2:0]  wr_mode = 3'h0;
  logic [3:0]  wr_ptr_sel = 4'h3, rd_ptr_sel = 4'h0;
  logic [15:0] rd_ea_in = 0, mstart = 0, mend = 0, ld_val = 0, ptr;
  logic [15:0] wr_ofs = 16'h0000;
  logic        ea_valid, ptr_wb, rev_active, rd_valid;
  logic [15:0] ea_out, ptr_new, rd_ea_out;
  int          n_mismatch = 0, num_checks = 0;

  bra_agu u_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pready(pready), .pslverr(pslverr), .prdata(prdata), .wr_req(wr_req),
    .wr_mode(wr_mode), .wr_ptr_sel(wr_ptr_sel), .wr_byte(wr_byte),
    .wr_ptr_val(ptr), .wr_offset(wr_ofs), .rd_req(rd_req),
    .rd_ptr_sel(rd_ptr_sel), .rd_ea_in(rd_ea_in), .modulo_start(mstart),
    .modulo_end(mend), .ea_valid(ea_valid), .ea_out(ea_out),
    .ptr_wb(ptr_wb), .ptr_new(ptr_new), .rev_active(rev_active),
    .rd_valid(rd_valid), .rd_ea_out(rd_ea_out));
  bra_core_model u_core (.pclk(pclk), .presetn(presetn), .load(ld),
    .load_val(ld_val), .ptr_wb(ptr_wb), .ptr_new(ptr_new), .ptr(ptr));

  initial
  begin
    pclk = 0;
    forever #5 pclk = ~pclk;
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic apb(input logic wr, input logic [7:0] a,
                     input logic [31:0] d, input logic [31:0] e,
                     input logic ee);
    @(posedge pclk);
    psel <= 1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    do @(posedge pclk); while (pready !== 1'b1);
    if (!wr && !ee)
      check(prdata, e);
    check(pslverr, ee);
    psel <= 0;
    penable <= 0;
  endtask

  task automatic load(input logic [15:0] v);
    @(posedge pclk);
    ld <= 1;
    ld_val <= v;
    @(posedge pclk);
    ld <= 0;
  endtask

  task automatic agu(input logic [2:0] m, input logic b,
                     input logic [15:0] e, input logic rv);
    @(posedge pclk);
    wr_req <= 1;
    wr_mode <= m;
    wr_byte <= b;
    @(posedge pclk);
    wr_req <= 0;
    @(posedge pclk);
    check(ea_valid, 1'b1);
    check(ea_out, e);
    check(rev_active, rv);
  endtask

  function automatic logic [3:0] rev4(input logic [3:0] v);
    return {v[0], v[1], v[2], v[3]};
  endfunction

  task automatic close_out();
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  initial
  begin
    #200us;
    n_mismatch++;
    close_out();
  end

  initial
  begin
    repeat (12) @(posedge pclk);
    presetn <= 1;
    apb(0, BRA_OFS_BIT_REVERSE_CONTROL, 0, 32'h0, 0);
    apb(0, BRA_OFS_ADDRESSING_MODE, 0, 32'h0f00, 0);
    apb(0, 8'h0c, 0, 0, 1);
    apb(1, BRA_OFS_STATUS, 32'h1, 0, 1);
    apb(1, BRA_OFS_BIT_REVERSE_CONTROL, 32'h8008, 0, 0);
    apb(0, BRA_OFS_STATUS, 0, 32'h0000_0002, 0);
    apb(0, BRA_OFS_STATUS, 0, 32'h0000_0000, 0);
    apb(0, BRA_OFS_BIT_REVERSE_CONTROL, 0, 32'h8008, 0);
    $display("test registers done");
    load(16'h0200);
    agu(BRA_AM_POST_INC, 0, 16'h0200, 0);
    apb(1, BRA_OFS_ADDRESSING_MODE, 32'h0300, 0, 0);
    load(16'h0200);
    for (int i = 0; i < 16; i++)
      agu(BRA_AM_POST_INC, 0, {11'h010, rev4(i[3:0]), 1'b0}, 1);
    agu(BRA_AM_PRE_INC, 0, 16'h0210, 1);
    load(16'h0211);
    agu(BRA_AM_POST_INC, 0, 16'h0210, 1);
    $display("test reversed sequence done");
    load(16'h0204);
    agu(BRA_AM_POST_INC, 1, 16'h0204, 0);
    agu(BRA_AM_INDIRECT, 0, 16'h0205, 0);
    wr_ptr_sel <= 4'h4;
    agu(BRA_AM_POST_INC, 0, 16'h0205, 0);
    wr_ptr_sel <= 4'h3;
    agu(BRA_AM_PRE_DEC, 0, 16'h0205, 0);
    wr_ofs <= 16'h0010;
    agu(BRA_AM_REG_OFS, 0, 16'h0215, 0);
    apb(1, BRA_OFS_BIT_REVERSE_CONTROL, 32'h0008, 0, 0);
    agu(BRA_AM_POST_INC, 0, 16'h0205, 0);
    $display("test fallback done");
    apb(1, BRA_OFS_BIT_REVERSE_CONTROL, 32'h8008, 0, 0);
    apb(1, BRA_OFS_ADDRESSING_MODE, 32'h8303, 0, 0);
    mstart <= 16'h0100;
    mend <= 16'h010e;
    load(16'h0200);
    agu(BRA_AM_POST_INC, 0, 16'h0200, 1);
    rd_req <= 1'b1;
    rd_ptr_sel <= 4'h3;
    rd_ea_in <= 16'h0110;
    @(posedge pclk);
    rd_req <= 1'b0;
    @(posedge pclk);
    check(rd_valid, 1'b1);
    check(rd_ea_out, 16'h0100);
    apb(1, BRA_OFS_BIT_REVERSE_CONTROL, 32'h0008, 0, 0);
    load(16'h010e);
    agu(BRA_AM_POST_INC, 0, 16'h010e, 0);
    agu(BRA_AM_POST_INC, 0, 16'h0100, 0);
    $display("test modulo priority done");
    close_out();
  end
endmodule

bind bra_agu bra_agu_properties u_prop (.pclk(pclk), .presetn(presetn),
  .psel(psel), .penable(penable), .pready(pready), .pslverr(pslverr),
  .wr_req(wr_req), .wr_mode(wr_mode), .wr_ptr_sel(wr_ptr_sel),
  .wr_byte(wr_byte), .wr_ptr_val(wr_ptr_val), .rd_req(rd_req),
  .ea_valid(ea_valid), .ea_out(ea_out), .ptr_wb(ptr_wb),
  .ptr_new(ptr_new), .rev_active(rev_active), .rd_valid(rd_valid));
`default_nettype wire
